// File: gas_alarm_consts.vh
`ifndef GAS_ALARM_CONSTS_VH
`define GAS_ALARM_CONSTS_VH
// ========================================
// register offsets (byte addresses)
`define OFS_CTRL 12'h000
`define OFS_THR_LS 12'h004
`define OFS_THR_EVACUATION_LEVEL 12'h008
`define OFS_STATUS 12'h00c
`define OFS_PEAK 12'h010
`define OFS_FAULT 12'h014
`define OFS_ACK 12'h018
`define OFS_PAGE 12'h01c
`define OFS_SUMMARY 12'h020
`define OFS_LOG_IDX 12'h024
`define OFS_LOG_EVT 12'h028
`define OFS_LOG_TIME 12'h02c
// ========================================
// control fields
`define CTRL_ACK_MODE 0
`define CTRL_HORN_EN 1
`define CTRL_FLT_RELAY_EN 2
`define CTRL_FLT_HORN_EN 3
`define CTRL_LOG_VIEW 4
`define CTRL_SILENCE 5
`define CTRL_RST 8'h01
// ========================================
// status fields
`define ST_ALARM 0
`define ST_SILENCE 1
`define ST_THR_REJECT 2
`define ST_HALT 3
`define ST_MORE 4
`define ST_COUNT_LSB 8
// ========================================
// reset thresholds in ppm
`define LEAK_RST 16'h0064
`define SPILL_RST 16'h012c
`define EVACUATION_LEVEL_RST 16'h01f4
// ========================================
// fault code groups
`define FAULT_CRITICAL 16'hff00
// ========================================
// flash timing, summary page size and log depth
`define FLASH_HALF_MS 500
`define CLK_KHZ 10000
`define PAGE_SIZE 8
`define LOG_DEPTH 20
`endif

// File: alarm_event_log.v
// ========================================
// ring of the most recent alarm events, index 0 is the newest
module alarm_event_log #(
  parameter DEPTH = 20,
  parameter W = 42,
  parameter IW = 5
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // write side
  input wire clear,
  input wire we,
  input wire [W-1:0] wdata,
  // read side
  input wire [IW-1:0] ridx,
  output reg [W-1:0] rdata,
  output reg [IW-1:0] count
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [IW-1:0] wptr;
  reg [IW:0] pos;

  always @*
  begin
    pos = {1'b0, wptr} + DEPTH[IW:0] - 1'b1 - {1'b0, ridx};
    if (pos >= DEPTH[IW:0])
      pos = pos - DEPTH[IW:0];
  end

  always @(posedge clk)
  begin
    if (rst || clear)
    begin
      wptr <= {IW{1'b0}};
      count <= {IW{1'b0}};
      rdata <= {W{1'b0}};
    end
    else
    begin
      // the oldest entry is simply overwritten once full
      if (we)
      begin
        mem[wptr] <= wdata;
        wptr <= (wptr == DEPTH[IW-1:0] - 1'b1) ? {IW{1'b0}} : wptr + 1'b1;
        if (count != DEPTH[IW-1:0])
          count <= count + 1'b1;
      end
      rdata <= (ridx < count) ? mem[pos[IW-1:0]] : {W{1'b0}};
    end
  end
endmodule // alarm_event_log

// File: gas_zone_alarm_manager.v
// Contract
// - zone above leak threshold raises a leak alarm.
// - zone above spill threshold raises a spill alarm.
// - zone above evacuation threshold raises an evacuation alarm.
// - thresholds accepted only when leak < spill < evacuation.
// - peak concentration is held, cleared on command, then tracks anew.
// - alarm shown only once the zone measurement has completed.
// - summary shows 8 alarms per page, flags a further page.
// - per alarm acknowledge flag; unacknowledged flash, acknowledged steady.
// - acknowledge mode decides whether acknowledgement is needed to clear.
// - all alarms acknowledged turns red indicator and alarm relays off.
// - new alarms keep rising after earlier acknowledgements.
// - confirmed silence opens leak relay and mutes horn only.
// - silence mode shows a flashing silence indicator.
// - silence cancelled when any zone clears or escalates.
// - last 20 alarm events kept with zone, type, time.
// - enter plus right while viewing the log clears it.
// - malfunction lights yellow fault, optional fault relay and horn.
// - non-critical fault keeps measuring, critical fault stops it.
// - fault code is cumulative, one bit per fault.
//
// Chosen here: the placing of the registers and the APB register port.
`include "gas_alarm_consts.vh"
module gas_zone_alarm_manager #(
  parameter ZONES = 16,
  parameter ZW = 4,
  parameter CW = 16,
  parameter FLASH_CYCLES = `FLASH_HALF_MS * `CLK_KHZ
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // measurement results
  input wire meas_valid,
  input wire [ZW-1:0] meas_zone,
  input wire [CW-1:0] present_concentration,
  input wire [31:0] time_stamp,
  // front panel keys and fault sources
  input wire key_enter,
  input wire key_right,
  input wire [15:0] fault_in,
  // indicators and relays
  output reg led_alarm,
  output reg led_fault,
  output reg relay_leak,
  output reg relay_spill,
  output reg relay_evacuation_level,
  output reg horn,
  output reg relay_fault,
  output reg silence_flash,
  output reg measure_halt
);
  // ========================================
  // state
  reg [7:0] ctrl;
  reg [CW-1:0] thr_leak, thr_spill, thr_evacuation_level, stage_leak, stage_spill;
  reg thr_reject;
  reg [CW-1:0] peak;
  reg [15:0] fault_code;
  reg [7:0] page;
  reg [4:0] log_idx;
  reg [2*ZONES-1:0] lvl, live;
  reg [ZONES-1:0] ack;
  reg silence;
  reg [31:0] flash_cnt;
  reg flash;
  reg [1:0] enter_q, right_q;
  reg [15:0] fault_q1, fault_q2;
  reg log_we;
  reg [41:0] log_wdata;
  wire [41:0] log_rdata;
  wire [4:0] log_count;

  // ========================================
  // decode helpers
  function [1:0] level_of;
    input [CW-1:0] c, l, s, e;
    begin
      if (c > e)
        level_of = 2'd3;
      else if (c > s)
        level_of = 2'd2;
      else if (c > l)
        level_of = 2'd1;
      else
        level_of = 2'd0;
    end
  endfunction

  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_LOG_TIME);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ========================================
  // summaries over all zones, and over the eight zones of the selected page
  reg [7:0] pend_cnt;
  reg any_unacked, any_pending, lvl1_un, lvl2_un, lvl3_un;
  reg [7:0] sum_pend, sum_flash;
  integer i, j;
  reg [10:0] zi;

  always @*
  begin
    pend_cnt = 8'h00;
    any_unacked = 1'b0;
    any_pending = 1'b0;
    lvl1_un = 1'b0;
    lvl2_un = 1'b0;
    lvl3_un = 1'b0;
    sum_pend = 8'h00;
    sum_flash = 8'h00;
    zi = 11'h000;
    for (i = 0; i < ZONES; i = i + 1)
    begin
      if (lvl[2*i +: 2] != 2'd0)
      begin
        pend_cnt = pend_cnt + 1'b1;
        any_pending = 1'b1;
        if (!ack[i])
        begin
          // acknowledged alarms drop out of the relay terms
          any_unacked = 1'b1;
          lvl1_un = 1'b1;
          if (lvl[2*i +: 2] >= 2'd2)
            lvl2_un = 1'b1;
          if (lvl[2*i +: 2] == 2'd3)
            lvl3_un = 1'b1;
        end
      end
    end
    for (i = 0; i < `PAGE_SIZE; i = i + 1)
    begin
      zi = {page, 3'b000} + i[10:0];
      if (zi < ZONES[10:0])
      begin
        sum_pend[i] = lvl[2*zi[ZW-1:0] +: 2] != 2'd0;
        sum_flash[i] = sum_pend[i] & ~ack[zi[ZW-1:0]] & flash;
      end
    end
  end

  wire more_page = pend_cnt > ({page, 3'b000} + `PAGE_SIZE);
  wire [1:0] new_lvl = level_of(present_concentration, thr_leak, thr_spill, thr_evacuation_level);
  wire [1:0] old_live = live[2*meas_zone +: 2];
  wire [1:0] old_lvl = lvl[2*meas_zone +: 2];
  wire take_meas = meas_valid & ~measure_halt;
  wire zone_change = take_meas && new_lvl != old_live && (new_lvl == 2'd0 || new_lvl > old_live);
  wire log_clear = ctrl[`CTRL_LOG_VIEW] & enter_q[1] & right_q[1];

  // ========================================
  // pin synchronisers, first stage feeds only the second
  always @(posedge clk)
  begin
    if (rst)
    begin
      enter_q <= 2'b00;
      right_q <= 2'b00;
      fault_q1 <= 16'h0000;
      fault_q2 <= 16'h0000;
    end
    else
    begin
      enter_q <= {enter_q[0], key_enter};
      right_q <= {right_q[0], key_right};
      fault_q1 <= fault_in;
      fault_q2 <= fault_q1;
    end
  end

  // ========================================
  // registers written by software
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= `CTRL_RST;
      thr_leak <= `LEAK_RST;
      thr_spill <= `SPILL_RST;
      thr_evacuation_level <= `EVACUATION_LEVEL_RST;
      stage_leak <= `LEAK_RST;
      stage_spill <= `SPILL_RST;
      thr_reject <= 1'b0;
      page <= 8'h00;
      log_idx <= 5'h00;
      fault_code <= 16'h0000;
    end
    else
    begin
      if (wr && hit(paddr, `OFS_CTRL))
        ctrl <= {3'b000, pwdata[4:0]};
      if (wr && hit(paddr, `OFS_THR_LS))
      begin
        stage_leak <= pwdata[CW-1:0];
        stage_spill <= pwdata[16 +: CW];
      end
      // writing evacuation commits all three, only if strictly ordered
      if (wr && hit(paddr, `OFS_THR_EVACUATION_LEVEL))
      begin
        if (stage_leak < stage_spill && stage_spill < pwdata[CW-1:0])
        begin
          thr_leak <= stage_leak;
          thr_spill <= stage_spill;
          thr_evacuation_level <= pwdata[CW-1:0];
        end
        else
          thr_reject <= 1'b1;
      end
      else if (wr && hit(paddr, `OFS_STATUS) && pwdata[`ST_THR_REJECT])
        thr_reject <= 1'b0;
      if (wr && hit(paddr, `OFS_PAGE))
        page <= pwdata[7:0];
      if (wr && hit(paddr, `OFS_LOG_IDX))
        log_idx <= pwdata[4:0];
      // new fault bits win over a clear in the same cycle
      fault_code <= (fault_code & ~((wr && hit(paddr, `OFS_FAULT)) ? pwdata[15:0] : 16'h0000))
        | fault_q2;
    end
  end

  // ========================================
  // zone alarm state
  always @(posedge clk)
  begin
    if (rst)
    begin
      lvl <= {2*ZONES{1'b0}};
      live <= {2*ZONES{1'b0}};
      ack <= {ZONES{1'b0}};
      peak <= {CW{1'b0}};
      log_we <= 1'b0;
      log_wdata <= 42'h0;
    end
    else
    begin
      log_we <= 1'b0;
      if (wr && hit(paddr, `OFS_ACK) && pwdata[ZW-1:0] < ZONES)
        ack[pwdata[ZW-1:0]] <= 1'b1;
      for (j = 0; j < ZONES; j = j + 1)
      begin
        if (lvl[2*j +: 2] != 2'd0 && live[2*j +: 2] == 2'd0 && (ack[j] || !ctrl[`CTRL_ACK_MODE]))
        begin
          lvl[2*j +: 2] <= 2'd0;
          ack[j] <= 1'b0;
        end
      end
      // the measured result is applied when the zone's cycle completes
      if (take_meas)
      begin
        live[2*meas_zone +: 2] <= new_lvl;
        if (new_lvl > old_lvl)
        begin
          lvl[2*meas_zone +: 2] <= new_lvl;
          ack[meas_zone] <= 1'b0;
          log_we <= 1'b1;
          log_wdata <= {new_lvl, {(8-ZW){1'b0}}, meas_zone, time_stamp};
        end
      end
      // a reset write clears, the same cycle's sample already becomes the new peak
      if (wr && hit(paddr, `OFS_PEAK))
        peak <= take_meas ? present_concentration : {CW{1'b0}};
      else if (take_meas && present_concentration > peak)
        peak <= present_concentration;
    end
  end

  // ========================================
  // silence mode and flash timing
  always @(posedge clk)
  begin
    if (rst)
    begin
      silence <= 1'b0;
      flash_cnt <= 32'h0;
      flash <= 1'b0;
    end
    else
    begin
      // a zone change beats a silence request in the same cycle
      if (zone_change || !any_pending)
        silence <= 1'b0;
      else if (wr && hit(paddr, `OFS_CTRL) && pwdata[`CTRL_SILENCE])
        silence <= 1'b1;
      if (flash_cnt >= FLASH_CYCLES - 1)
      begin
        flash_cnt <= 32'h0;
        flash <= ~flash;
      end
      else
        flash_cnt <= flash_cnt + 1'b1;
    end
  end

  // ========================================
  // indicators and relays
  always @(posedge clk)
  begin
    if (rst)
    begin
      led_alarm <= 1'b0;
      led_fault <= 1'b0;
      relay_leak <= 1'b0;
      relay_spill <= 1'b0;
      relay_evacuation_level <= 1'b0;
      horn <= 1'b0;
      relay_fault <= 1'b0;
      silence_flash <= 1'b0;
      measure_halt <= 1'b0;
    end
    else
    begin
      led_alarm <= any_unacked;
      relay_leak <= lvl1_un & ~silence;
      relay_spill <= lvl2_un;
      relay_evacuation_level <= lvl3_un;
      horn <= (any_unacked & ctrl[`CTRL_HORN_EN] & ~silence)
        | ((|fault_code) & ctrl[`CTRL_FLT_HORN_EN]);
      led_fault <= |fault_code;
      relay_fault <= (|fault_code) & ctrl[`CTRL_FLT_RELAY_EN];
      silence_flash <= silence & flash;
      measure_halt <= |(fault_code & `FAULT_CRITICAL);
    end
  end

  // ========================================
  // event log
  alarm_event_log #(
    .DEPTH(`LOG_DEPTH),
    .W(42),
    .IW(5)
  ) u_log (
    .clk(clk),
    .rst(rst),
    .clear(log_clear),
    .we(log_we),
    .wdata(log_wdata),
    .ridx(log_idx),
    .rdata(log_rdata),
    .count(log_count)
  );

  // ========================================
  // read data, captured in the setup cycle
  always @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h0;
    else if (setup && !pwrite)
    begin
      case (paddr)
        `OFS_CTRL: prdata <= {24'h0, ctrl};
        `OFS_THR_LS: prdata <= {thr_spill, thr_leak};
        `OFS_THR_EVACUATION_LEVEL: prdata <= {16'h0, thr_evacuation_level};
        `OFS_STATUS: prdata <= {11'h0, log_count, pend_cnt, 3'b000, more_page,
          measure_halt, thr_reject, silence, any_unacked};
        `OFS_PEAK: prdata <= {16'h0, peak};
        `OFS_FAULT: prdata <= {16'h0, fault_code};
        `OFS_PAGE: prdata <= {24'h0, page};
        `OFS_SUMMARY: prdata <= {more_page, 15'h0, sum_flash, sum_pend};
        `OFS_LOG_IDX: prdata <= {27'h0, log_idx};
        `OFS_LOG_EVT: prdata <= {22'h0, log_rdata[41:32]};
        `OFS_LOG_TIME: prdata <= log_rdata[31:0];
        default: prdata <= 32'h0;
      endcase
    end
  end
endmodule // gas_zone_alarm_manager

// File: gas_alarm_checker.sv
// ==========
// port level checks of the alarm manager
module gas_alarm_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched ports
  input wire meas_valid,
  input wire led_alarm,
  input wire led_fault,
  input wire relay_leak,
  input wire relay_spill,
  input wire relay_evacuation_level,
  input wire horn,
  input wire relay_fault,
  input wire silence_flash,
  input wire measure_halt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_leak_needs_red: assert property (relay_leak |-> led_alarm)
    else $error("leak relay on without alarm");
  a_spill_needs_red: assert property (relay_spill |-> led_alarm)
    else $error("spill relay on without alarm");
  a_evacuation_level_over_spill: assert property (relay_evacuation_level |-> relay_spill)
    else $error("evacuation_level relay without spill relay");
  a_silence_leak_open: assert property (silence_flash |-> !relay_leak && (!horn || led_fault))
    else $error("leak relay or horn on while silenced");
  a_red_after_meas: assert property ($rose(led_alarm) |-> $past(meas_valid, 2))
    else $error("alarm lit without completed measurement");
  a_fault_relay_yellow: assert property (relay_fault |-> led_fault)
    else $error("fault relay without fault led");
  a_halt_is_fault: assert property (measure_halt |-> led_fault)
    else $error("halt without fault led");
  a_horn_has_cause: assert property (horn |-> led_alarm || led_fault)
    else $error("horn without alarm or fault");
endmodule // gas_alarm_checker

bind gas_zone_alarm_manager gas_alarm_checker i_gas_alarm_checker (.clk, .rst, .meas_valid, .led_alarm,
  .led_fault, .relay_leak, .relay_spill, .relay_evacuation_level, .horn, .relay_fault, .silence_flash, .measure_halt);

// File: remote_display_model.sv
// ==========
// remote display: polls the monitor on a fixed period, poll time scaled down
module remote_display_model #(
  parameter POLL = 20
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // monitor status seen on a poll
  input wire led_alarm,
  input wire led_fault,
  // display indicators
  output logic rd_red,
  output logic rd_yellow
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= 0;
      rd_red <= 0;
      rd_yellow <= 0;
    end
    else if (cnt == POLL - 1)
    begin
      cnt <= 0;
      // single monitor, so its ack state is the whole network's
      rd_red <= led_alarm;
      rd_yellow <= led_fault;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // remote_display_model

// File: testbench.sv
`include "gas_alarm_consts.vh"
// ==========
// testbench
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
  logic clk = 0;
  logic rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, meas_valid = 0, key_enter = 0, key_right = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, time_stamp = 0, q;
  logic [3:0] meas_zone = 0;
  logic [15:0] present_concentration = 0, fault_in = 0;
  wire [31:0] prdata;
  wire pready, pslverr, led_alarm, led_fault, relay_leak, relay_spill, relay_evacuation_level, horn;
  wire relay_fault, silence_flash, measure_halt, rd_red, rd_yellow;
  int miscompares = 0;
  int total_checks = 0;
  int k;
  always #50 clk = ~clk;
  always @(posedge clk) time_stamp <= time_stamp + 1;
  // short flash period keeps the silence scenario brief
  gas_zone_alarm_manager #(.FLASH_CYCLES(4)) i_gas_zone_alarm_manager (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_valid, .meas_zone, .present_concentration,
    .time_stamp, .key_enter, .key_right, .fault_in, .led_alarm, .led_fault, .relay_leak, .relay_spill,
    .relay_evacuation_level, .horn, .relay_fault, .silence_flash, .measure_halt);
  remote_display_model #(.POLL(20)) i_remote_display_model (.clk, .rst, .led_alarm, .led_fault, .rd_red,
    .rd_yellow);
  task results;
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
    if (n >= 20)
    begin
      miscompares++;
      results();
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1, a, d);
  endtask
  task rd(input logic [11:0] a);
    xfer(0, a, 0);
  endtask
  task meas(input logic [3:0] z, input logic [15:0] c);
    @(posedge clk);
    meas_valid <= 1;
    meas_zone <= z;
    present_concentration <= c;
    @(posedge clk);
    meas_valid <= 0;
    idle(3);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    rd(`OFS_CTRL);
    `CHK("ctrl", 32'h1, q)
    rd(12'h030);
    `CHK("unmapped", 33'h100000000, {err, q})
    wr(`OFS_THR_LS, 32'h012c0190);
    wr(`OFS_THR_EVACUATION_LEVEL, 32'h1f4);
    rd(`OFS_STATUS);
    `CHK("reject", 1'b1, q[`ST_THR_REJECT])
    rd(`OFS_THR_LS);
    `CHK("thr_kept", 32'h012c0064, q)
    wr(`OFS_THR_LS, 32'h00c80064);
    wr(`OFS_THR_EVACUATION_LEVEL, 32'h12c);
    rd(`OFS_THR_LS);
    `CHK("thr_new", 32'h00c80064, q)
    wr(`OFS_CTRL, 32'h3);
    meas(1, 101);
    `CHK("leak", 5'b11001, {led_alarm, relay_leak, relay_spill, relay_evacuation_level, horn})
    meas(2, 201);
    `CHK("spill", 3'b110, {relay_leak, relay_spill, relay_evacuation_level})
    meas(3, 301);
    meas(4, 100);
    `CHK("evacuation_level", 1'b1, relay_evacuation_level)
    rd(`OFS_STATUS);
    `CHK("count", 8'd3, q[15:8])
    idle(22);
    `CHK("rd_red", 1'b1, rd_red)
    wr(`OFS_CTRL, 32'h23);
    idle(3);
    `CHK("silence", 4'b0110, {relay_leak, relay_spill, relay_evacuation_level, horn})
    for (k = 0; k < 20 && silence_flash !== 1'b1; k++) idle(1);
    `CHK("flash", 1'b1, silence_flash)
    meas(1, 250);
    rd(`OFS_STATUS);
    `CHK("cancel", 2'b01, q[1:0])
    rd(`OFS_PEAK);
    `CHK("peak", 32'd301, q)
    wr(`OFS_PEAK, 0);
    meas(4, 50);
    rd(`OFS_PEAK);
    `CHK("peak_new", 32'd50, q)
    for (k = 1; k < 4; k++) wr(`OFS_ACK, k);
    idle(3);
    `CHK("acked", 4'b0, {led_alarm, relay_spill, relay_evacuation_level, horn})
    idle(22);
    `CHK("rd_normal", 1'b0, rd_red)
    meas(1, 0);
    meas(5, 150);
    `CHK("new", 1'b1, led_alarm)
    rd(`OFS_STATUS);
    `CHK("cleared", 8'd3, q[15:8])
    wr(`OFS_CTRL, 0);
    meas(5, 0);
    rd(`OFS_STATUS);
    `CHK("no_ack", 8'd2, q[15:8])
    wr(`OFS_CTRL, 1);
    for (k = 6; k < 16; k++) meas(k, 150);
    rd(`OFS_SUMMARY);
    `CHK("page0", 32'h800000cc, q & 32'h800000ff)
    `CHK("steady", 2'b0, q[11:10])
    wr(`OFS_PAGE, 1);
    rd(`OFS_SUMMARY);
    `CHK("page1", 32'hff, q & 32'h800000ff)
    for (k = 0; k < 16; k++) meas(k, 250);
    rd(`OFS_STATUS);
    `CHK("log_count", 5'd20, q[20:16])
    wr(`OFS_LOG_IDX, 19);
    rd(`OFS_LOG_EVT);
    `CHK("oldest", 32'h10a, q & 32'h3ff)
    wr(`OFS_LOG_IDX, 0);
    rd(`OFS_LOG_EVT);
    `CHK("newest", 32'h20f, q & 32'h3ff)
    wr(`OFS_CTRL, 32'h11);
    @(posedge clk);
    key_enter <= 1;
    key_right <= 1;
    idle(5);
    @(posedge clk);
    key_enter <= 0;
    key_right <= 0;
    rd(`OFS_STATUS);
    `CHK("log_clear", 5'd0, q[20:16])
    wr(`OFS_CTRL, 32'h5);
    @(posedge clk);
    fault_in <= 16'h4200;
    idle(6);
    `CHK("fault_pins", 3'b111, {led_fault, relay_fault, measure_halt})
    meas(0, 16'd400);
    rd(`OFS_PEAK);
    `CHK("halt_peak", 32'd250, q)
    rd(`OFS_FAULT);
    `CHK("code", 32'h4200, q)
    @(posedge clk);
    fault_in <= 16'h0001;
    idle(5);
    wr(`OFS_FAULT, 32'h4200);
    idle(3);
    rd(`OFS_FAULT);
    `CHK("code_nc", 32'h1, q)
    `CHK("nc_pins", 2'b10, {led_fault, measure_halt})
    idle(22);
    `CHK("rd_yellow", 1'b1, rd_yellow)
    results();
  end
endmodule // testbench
